//--- verilog/tec_timer.sv
// Behaviour
// - count advances on prescaled clock (timer) or on external events (counter mode)
// - 32-bit counter fed by a programmable 32-bit prescaler
// - four match registers; equal count raises optional interrupt, counting continues
// - per match, optional halt of the counter on match
// - per match, optional reset of the counter to zero on match
// - four capture channels latch count on input edges, optional interrupt
// - four match outputs: go low, go high, toggle or stay per setting
// - capture lines not used as count source still capture or interrupt
// - several pins per capture (OR/AND) and match broadcast to several pins
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"
module tec_timer #(
   parameter int NPIN = 8
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire tec_pkg::tec_axi_wr_t wr_i,
   input wire tec_pkg::tec_axi_rd_t rd_i,
   output logic awready_o,
   output logic wready_o,
   output logic bvalid_o,
   output logic [1:0] bresp_o,
   output logic arready_o,
   output logic rvalid_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   input wire logic [NPIN-1:0] cap_pin_i,
   output logic [NPIN-1:0] match_pin_o,
   output logic irq_o
);
   import tec_pkg::*;

   // ****************************************
   // state
   // ****************************************
   logic [31:0] ctrl_r, ctrl_nxt, tc_r, tc_nxt, pr_r, pr_nxt, pc_r, pc_nxt;
   logic [11:0] mctl_r, mctl_nxt;
   logic [11:0] cctl_r, cctl_nxt;
   logic [7:0] octl_r, octl_nxt;
   logic [7:0] ist_r, ist_nxt, imsk_r, imsk_nxt;
   logic [31:0] psel_r, psel_nxt;
   logic [31:0] mr_r [4], mr_nxt [4], cr_r [4], cr_nxt [4];
   logic [3:0] mo_r, mo_nxt;
   logic [3:0] s1_r, s2_r, s3_r, hit_r;
   logic aw_r, aw_nxt, w_r, w_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
   logic [11:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt, rd_r, rd_nxt;
   logic [3:0] ws_r, ws_nxt;
   logic [1:0] br_r, br_nxt, rr_r, rr_nxt;

   // ****************************************
   // pin combining and synchronising
   // ****************************************
   logic [3:0] cap_raw, cap_rise, cap_fall, mhit, mev;
   // pin select holds two bits per channel; cctl bit 3g+2 picks the and-combine
   genvar g;
   for (g = 0; g < 4; g++)
   begin : g_chan
      wire logic [1:0] sel = psel_r[g*2 +: 2];
      // each channel owns pins g and g+4; select which join, combine OR or AND
      assign cap_raw[g] = cctl_r[g*3+2]
         ? ((cap_pin_i[g] | ~sel[0]) & (cap_pin_i[g+4] | ~sel[1]) & (|sel))
         : ((cap_pin_i[g] & sel[0]) | (cap_pin_i[g+4] & sel[1]));
      // second and third stage only: first stage feeds nothing else
      assign cap_rise[g] = s2_r[g] & ~s3_r[g];
      assign cap_fall[g] = ~s2_r[g] & s3_r[g];
      assign mhit[g] = ctrl_r[`TEC_CTRL_EN] && (tc_r == mr_r[g]);
      // a held count would toggle every clock, so output actions use the first cycle only
      assign mev[g] = mhit[g] & ~hit_r[g];
      // match output broadcast to pins g and g+4
      assign match_pin_o[g] = mo_r[g];
      assign match_pin_o[g+4] = mo_r[g];
   end
   // ****************************************
   // counting logic
   // ****************************************
   logic tick, ev_edge, stop_any, rst_any;
   logic [1:0] esrc;
   logic [3:0] cap_ev;
   always_comb
   begin
      esrc = ctrl_r[`TEC_CTRL_ESRC_LO +: 2];
      // qualifying edge of the synchronised event source
      case (ctrl_r[`TEC_CTRL_EDGE_LO +: 2])
         2'd0: ev_edge = cap_rise[esrc];
         2'd1: ev_edge = cap_fall[esrc];
         2'd2: ev_edge = cap_rise[esrc] | cap_fall[esrc];
         default: ev_edge = 1'b0;
      endcase
      // timer mode ticks every clock, counter mode on events
      tick = ctrl_r[`TEC_CTRL_MODE] ? ev_edge : 1'b1;
      stop_any = 1'b0;
      rst_any = 1'b0;
      for (int i = 0; i < 4; i++)
      begin
         stop_any = stop_any | (mhit[i] & mctl_r[i*3+2]);
         rst_any = rst_any | (mhit[i] & mctl_r[i*3+1]);
         // source channel stays a capture in counter mode too
         cap_ev[i] = (cctl_r[i*3] & cap_rise[i]) | (cctl_r[i*3+1] & cap_fall[i]);
      end
   end

   // ****************************************
   // bus decode
   // ****************************************
   logic do_wr, do_rd, wr_ok, rd_ok;
   logic [31:0] wmask, rval;
   assign awready_o = ~aw_r & ~bv_r;
   assign wready_o = ~w_r & ~bv_r;
   assign arready_o = ~rv_r;
   assign bvalid_o = bv_r;
   assign bresp_o = br_r;
   assign rvalid_o = rv_r;
   assign rdata_o = rd_r;
   assign rresp_o = rr_r;
   assign irq_o = |(ist_r & imsk_r);
   assign do_wr = aw_r & w_r & ~bv_r;
   assign do_rd = rd_i.arvalid & ~rv_r;
   for (g = 0; g < 4; g++)
   begin : g_mask
      assign wmask[g*8 +: 8] = {8{ws_r[g]}};
   end
   // read mux and main next-state
   always_comb
   begin
      {ctrl_nxt, tc_nxt, pr_nxt, pc_nxt, psel_nxt} = {ctrl_r, tc_r, pr_r, pc_r, psel_r};
      {mctl_nxt, cctl_nxt, octl_nxt} = {mctl_r, cctl_r, octl_r};
      {imsk_nxt, ist_nxt, mo_nxt} = {imsk_r, ist_r, mo_r};
      mr_nxt = mr_r;
      cr_nxt = cr_r;
      {aw_nxt, w_nxt, awa_nxt, wd_nxt, ws_nxt} = {aw_r, w_r, awa_r, wd_r, ws_r};
      {bv_nxt, br_nxt, rv_nxt, rd_nxt, rr_nxt} = {bv_r, br_r, rv_r, rd_r, rr_r};
      wr_ok = 1'b1;
      rd_ok = 1'b1;
      rval = 32'h0000_0000;
      // counter: prescaler divides the tick, then count or reset
      if (ctrl_r[`TEC_CTRL_EN] && tick)
      begin
         if (pc_r >= pr_r)
         begin
            pc_nxt = 32'h0000_0000;
            tc_nxt = tc_r + 32'h0000_0001;
         end
         else
            pc_nxt = pc_r + 32'h0000_0001;
      end
      // a match reset clears count at the next tick slot
      if (rst_any && ctrl_r[`TEC_CTRL_EN] && tick && pc_r >= pr_r)
         tc_nxt = 32'h0000_0000;
      // match stop halts the counter by dropping enable
      if (stop_any)
      begin
         ctrl_nxt[`TEC_CTRL_EN] = 1'b0;
         tc_nxt = tc_r;
         pc_nxt = pc_r;
      end
      if (ctrl_r[`TEC_CTRL_CRST])
      begin
         tc_nxt = 32'h0000_0000;
         pc_nxt = 32'h0000_0000;
      end
      // ---- axi capture of address and data ----
      if (wr_i.awvalid && awready_o)
      begin
         aw_nxt = 1'b1;
         awa_nxt = wr_i.awaddr;
      end
      if (wr_i.wvalid && wready_o)
      begin
         w_nxt = 1'b1;
         wd_nxt = wr_i.wdata;
         ws_nxt = wr_i.wstrb;
      end
      if (bv_r && wr_i.bready)
         bv_nxt = 1'b0;
      if (rv_r && rd_i.rready)
         rv_nxt = 1'b0;
      // ---- register writes ----
      if (do_wr)
      begin
         aw_nxt = 1'b0;
         w_nxt = 1'b0;
         bv_nxt = 1'b1;
         case (awa_r & 12'hFFC)
            `TEC_OFS_CTRL: ctrl_nxt = (ctrl_r & ~wmask) | (wd_r & wmask);
            `TEC_OFS_COUNT: tc_nxt = (tc_r & ~wmask) | (wd_r & wmask);
            `TEC_OFS_PRE: pr_nxt = (pr_r & ~wmask) | (wd_r & wmask);
            `TEC_OFS_PCNT: pc_nxt = (pc_r & ~wmask) | (wd_r & wmask);
            `TEC_OFS_MCTRL: mctl_nxt = (mctl_r & ~wmask[11:0]) | (wd_r[11:0] & wmask[11:0]);
            `TEC_OFS_CCTRL: cctl_nxt = (cctl_r & ~wmask[11:0]) | (wd_r[11:0] & wmask[11:0]);
            `TEC_OFS_OCTRL: octl_nxt = (octl_r & ~wmask[7:0]) | (wd_r[7:0] & wmask[7:0]);
            `TEC_OFS_ISTAT: ist_nxt = ist_r & ~(wd_r[7:0] & wmask[7:0]);
            `TEC_OFS_IMASK: imsk_nxt = (imsk_r & ~wmask[7:0]) | (wd_r[7:0] & wmask[7:0]);
            `TEC_OFS_PINSEL: psel_nxt = (psel_r & ~wmask) | (wd_r & wmask);
            default:
               if ((awa_r & 12'hFF0) == `TEC_OFS_MATCH0)
                  mr_nxt[awa_r[3:2]] = (mr_r[awa_r[3:2]] & ~wmask) | (wd_r & wmask);
               else
                  wr_ok = 1'b0;
         endcase
         br_nxt = wr_ok ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
      end
      // ---- events: set wins over software clear ----
      for (int i = 0; i < 4; i++)
      begin
         // match interrupt flag, count keeps going unless stopped
         if (mhit[i] && mctl_r[i*3])
            ist_nxt[i] = 1'b1;
         // capture latches count and flags it; the mask makes it optional
         if (cap_ev[i])
         begin
            cr_nxt[i] = tc_r;
            ist_nxt[i+4] = 1'b1;
         end
         // match output action, once per match
         if (mev[i])
            case (tec_act_t'(octl_r[i*2 +: 2]))
               TEC_ACT_LOW: mo_nxt[i] = 1'b0;
               TEC_ACT_HIGH: mo_nxt[i] = 1'b1;
               TEC_ACT_TOGGLE: mo_nxt[i] = ~mo_r[i];
               default: mo_nxt[i] = mo_r[i];
            endcase
      end
      // ---- register reads ----
      if (do_rd)
      begin
         case (rd_i.araddr & 12'hFFC)
            `TEC_OFS_CTRL: rval = ctrl_r;
            `TEC_OFS_COUNT: rval = tc_r;
            `TEC_OFS_PRE: rval = pr_r;
            `TEC_OFS_PCNT: rval = pc_r;
            `TEC_OFS_MCTRL: rval = {20'h0_0000, mctl_r};
            `TEC_OFS_CCTRL: rval = {20'h0_0000, cctl_r};
            `TEC_OFS_OCTRL: rval = {24'h00_0000, octl_r};
            `TEC_OFS_ISTAT: rval = {24'h00_0000, ist_r};
            `TEC_OFS_IMASK: rval = {24'h00_0000, imsk_r};
            `TEC_OFS_PINSEL: rval = psel_r;
            default:
               if ((rd_i.araddr & 12'hFF0) == `TEC_OFS_MATCH0)
                  rval = mr_r[rd_i.araddr[3:2]];
               else if ((rd_i.araddr & 12'hFF0) == `TEC_OFS_CAP0)
                  rval = cr_r[rd_i.araddr[3:2]];
               else
                  rd_ok = 1'b0;
         endcase
         rv_nxt = 1'b1;
         rd_nxt = rval;
         rr_nxt = rd_ok ? `TEC_RESP_OKAY : `TEC_RESP_SLVERR;
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         {ctrl_r, tc_r, pr_r, pc_r} <= {4{`TEC_RST_WORD}};
         {mctl_r, cctl_r, octl_r, ist_r, imsk_r} <= 48'h0000_0000_0000;
         psel_r <= `TEC_RST_PINSEL;
         mr_r <= '{default: `TEC_RST_WORD};
         cr_r <= '{default: `TEC_RST_WORD};
         {mo_r, s1_r, s2_r, s3_r, hit_r} <= 20'h0_0000;
         {aw_r, w_r, awa_r, wd_r, ws_r} <= 50'h0_0000_0000_0000;
         {bv_r, br_r, rv_r, rd_r, rr_r} <= 38'h00_0000_0000;
      end
      else
      begin
         {ctrl_r, tc_r, pr_r, pc_r, psel_r} <= {ctrl_nxt, tc_nxt, pr_nxt, pc_nxt, psel_nxt};
         {mctl_r, cctl_r, octl_r} <= {mctl_nxt, cctl_nxt, octl_nxt};
         {imsk_r, ist_r, mo_r} <= {imsk_nxt, ist_nxt, mo_nxt};
         mr_r <= mr_nxt;
         cr_r <= cr_nxt;
         // synchroniser chain: inputs counted only after two flops
         s1_r <= cap_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         hit_r <= mhit; // remembers a match so its output action fires once
         {aw_r, w_r, awa_r, wd_r, ws_r} <= {aw_nxt, w_nxt, awa_nxt, wd_nxt, ws_nxt};
         {bv_r, br_r, rv_r, rd_r, rr_r} <= {bv_nxt, br_nxt, rv_nxt, rd_nxt, rr_nxt};
      end
   end

   // ****************************************
   // checks
   // ****************************************
   property p_stop;
      @(posedge core_clk_i) disable iff (!arst_n_i) (stop_any && !do_wr) |=> !ctrl_r[`TEC_CTRL_EN];
   endproperty
   a_stop: assert property (p_stop) else $error("stop on match failed");
   property p_cap;
      @(posedge core_clk_i) disable iff (!arst_n_i) cap_ev[2] |=> (cr_r[2] == $past(tc_r) && ist_r[6]);
   endproperty
   a_cap: assert property (p_cap) else $error("capture 2 missed");
   property p_mint;
      @(posedge core_clk_i) disable iff (!arst_n_i) (mhit[1] && mctl_r[3]) |=> ist_r[1];
   endproperty
   a_mint: assert property (p_mint) else $error("match 1 flag not set");
   property p_tog;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (mev[1] && octl_r[3:2] == 2'd3) |=> (mo_r[1] != $past(mo_r[1]));
   endproperty
   a_tog: assert property (p_tog) else $error("toggle failed");
   property p_irq;
      @(posedge core_clk_i) disable iff (!arst_n_i) irq_o == (|(ist_r & imsk_r));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");
   property p_bcast;
      @(posedge core_clk_i) disable iff (!arst_n_i) match_pin_o[2] == match_pin_o[6];
   endproperty
   a_bcast: assert property (p_bcast) else $error("broadcast mismatch");
   property p_hold;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (!ctrl_r[`TEC_CTRL_EN] && !do_wr && !ctrl_r[`TEC_CTRL_CRST]) |=> $stable(tc_r);
   endproperty
   a_hold: assert property (p_hold) else $error("count moved while stopped");
   property p_timer;
      @(posedge core_clk_i) disable iff (!arst_n_i)
         (ctrl_r[2:0] == 3'b001 && pr_r == 32'h0000_0000 && !stop_any && !rst_any && !do_wr)
         |=> tc_r == $past(tc_r) + 32'h0000_0001;
   endproperty
   a_timer: assert property (p_timer) else $error("timer did not count");
   property p_rsp;
      @(posedge core_clk_i) disable iff (!arst_n_i) do_rd |=> rvalid_o;
   endproperty
   a_rsp: assert property (p_rsp) else $error("no read answer");
   c_stop: cover property (@(posedge core_clk_i) stop_any);
   c_rst: cover property (@(posedge core_clk_i) rst_any);
   c_cap: cover property (@(posedge core_clk_i) cap_ev[2]);
endmodule : tec_timer
`default_nettype wire

//--- verilog/tec_cfg.svh
`ifndef TEC_CFG_SVH
`define TEC_CFG_SVH
// register byte offsets
`define TEC_OFS_CTRL 12'h000
`define TEC_OFS_COUNT 12'h004
`define TEC_OFS_PRE 12'h008
`define TEC_OFS_PCNT 12'h00C
`define TEC_OFS_MCTRL 12'h010
`define TEC_OFS_CCTRL 12'h014
`define TEC_OFS_OCTRL 12'h018
`define TEC_OFS_ISTAT 12'h01C
`define TEC_OFS_IMASK 12'h020
`define TEC_OFS_PINSEL 12'h024
`define TEC_OFS_MATCH0 12'h040
`define TEC_OFS_CAP0 12'h060
// control register fields
`define TEC_CTRL_EN 0
`define TEC_CTRL_CRST 1
`define TEC_CTRL_MODE 2
`define TEC_CTRL_ESRC_LO 4
`define TEC_CTRL_EDGE_LO 6
// reset values
`define TEC_RST_WORD 32'h0000_0000
`define TEC_RST_PINSEL 32'h0000_0055
// axi response codes
`define TEC_RESP_OKAY 2'b00
`define TEC_RESP_SLVERR 2'b10
`endif

//--- verilog/tec_pkg.sv
package tec_pkg;
   // output action on match
   typedef enum logic [1:0] {TEC_ACT_NONE, TEC_ACT_LOW, TEC_ACT_HIGH, TEC_ACT_TOGGLE} tec_act_t;
   // per-match control: interrupt, reset, stop
   typedef struct packed {
      logic stop;
      logic rst;
      logic irq;
   } tec_mctl_t;
   // axi4-lite write request from master
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
   } tec_axi_wr_t;
   // axi4-lite read request from master
   typedef struct packed {
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } tec_axi_rd_t;
endpackage : tec_pkg

//--- verification/tec_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far side: capture sources and match loads
// ****************************************
module tec_pin_model (
   input wire logic core_clk_i,
   input wire logic [7:0] match_pin_i,
   output logic [7:0] cap_pin_o
);
   int err_cnt = 0;
   int toggles = 0;
   logic prev_pin1 = 1'b0;
   initial cap_pin_o = 8'h00;
   // each level lasts four clocks, well over one period, so no edge is lost
   task automatic pulse(input logic [7:0] m, input int n);
      repeat (n)
      begin
         cap_pin_o <= m;
         repeat (4) @(posedge core_clk_i);
         cap_pin_o <= 8'h00;
         repeat (4) @(posedge core_clk_i);
      end
   endtask : pulse
   // both pins of a match must carry the same level; count toggles of match 1
   always @(posedge core_clk_i)
   begin
      if (match_pin_i[3:0] !== match_pin_i[7:4])
      begin
         err_cnt++;
         $display("Error at %0t: match pins differ %h", $time, match_pin_i);
      end
      if (match_pin_i[1] !== prev_pin1)
         toggles++;
      prev_pin1 <= match_pin_i[1];
   end
endmodule : tec_pin_model
`default_nettype wire

//--- verification/timer_event_counter_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tec_cfg.svh"
module timer_event_counter_bench;
   import tec_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   tec_axi_wr_t wr_q = '0;
   tec_axi_rd_t rd_q = '0;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
   logic [1:0] bresp_o, rresp_o;
   logic [31:0] rdata_o;
   logic [7:0] cap_pin, match_pin;
   int bad_count = 0;
   int checks_done = 0;
   int cyc = 0;
   always #4 core_clk = ~core_clk;
   tec_timer #(.NPIN(8)) i_dut (.core_clk_i(core_clk), .arst_n_i(arst_n), .wr_i(wr_q),
      .rd_i(rd_q), .awready_o(awready_o), .wready_o(wready_o), .bvalid_o(bvalid_o),
      .bresp_o(bresp_o), .arready_o(arready_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
      .rresp_o(rresp_o), .cap_pin_i(cap_pin), .match_pin_o(match_pin), .irq_o(irq_o));
   tec_pin_model i_pins (.core_clk_i(core_clk), .match_pin_i(match_pin), .cap_pin_o(cap_pin));
   // ****************************************
   // bus tasks and comparison
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      wr_q.awaddr <= a;
      wr_q.wdata <= d;
      wr_q.wstrb <= 4'hf;
      wr_q.awvalid <= 1'b1;
      wr_q.wvalid <= 1'b1;
      wr_q.bready <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge core_clk);
         aw_done = aw_done | (awready_o === 1'b1);
         w_done = w_done | (wready_o === 1'b1);
         wr_q.awvalid <= !aw_done;
         wr_q.wvalid <= !w_done;
      end
      do @(posedge core_clk); while (bvalid_o !== 1'b1);
      r = bresp_o;
      wr_q.bready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_wr
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      rd_q.araddr <= a;
      rd_q.arvalid <= 1'b1;
      rd_q.rready <= 1'b1;
      do @(posedge core_clk); while (arready_o !== 1'b1);
      rd_q.arvalid <= 1'b0;
      do @(posedge core_clk); while (rvalid_o !== 1'b1);
      d = rdata_o;
      r = rresp_o;
      rd_q.rready <= 1'b0;
      @(posedge core_clk);
   endtask : axi_rd
   task automatic wok(input logic [11:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_wr(a, d, r);
      chk({30'd0, r}, {30'd0, `TEC_RESP_OKAY});
   endtask : wok
   task automatic rchk(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(a, d, r);
      chk({30'd0, r}, {30'd0, `TEC_RESP_OKAY});
      chk(d, e);
   endtask : rchk
   // ****************************************
   // scenarios
   // ****************************************
   // reset values, unmapped and read-only places refused
   task automatic t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rchk(`TEC_OFS_CTRL, 32'h0000_0000);
      rchk(`TEC_OFS_PINSEL, `TEC_RST_PINSEL);
      rchk(`TEC_OFS_ISTAT, 32'h0000_0000);
      axi_rd(12'h030, d, r);
      chk({30'd0, r}, {30'd0, `TEC_RESP_SLVERR});
      axi_wr(`TEC_OFS_CAP0, 32'h1234_5678, r);
      chk({30'd0, r}, {30'd0, `TEC_RESP_SLVERR});
      rchk(`TEC_OFS_CAP0, 32'h0000_0000);
   endtask : t_regs
   // prescaled count halts at match 0, drives its pins high, flag masked then seen
   task automatic t_stop();
      wok(`TEC_OFS_PRE, 32'h0000_0003);
      wok(`TEC_OFS_MATCH0, 32'h0000_0005);
      wok(`TEC_OFS_MCTRL, 32'h0000_0005);
      wok(`TEC_OFS_OCTRL, 32'h0000_0002);
      wok(`TEC_OFS_CTRL, 32'h0000_0001);
      repeat (10) @(posedge core_clk);
      rchk(`TEC_OFS_ISTAT, 32'h0000_0000);
      repeat (40) @(posedge core_clk);
      rchk(`TEC_OFS_COUNT, 32'h0000_0005);
      rchk(`TEC_OFS_CTRL, 32'h0000_0000);
      rchk(`TEC_OFS_ISTAT, 32'h0000_0001);
      chk({31'd0, irq_o}, 32'd0);
      wok(`TEC_OFS_IMASK, 32'h0000_0001);
      chk({31'd0, irq_o}, 32'd1);
      chk({31'd0, match_pin[0]}, 32'd1);
      wok(`TEC_OFS_ISTAT, 32'h0000_0001);
      chk({31'd0, irq_o}, 32'd0);
   endtask : t_stop
   // reset on match 1 keeps the count within 0..3; low, toggle and none actions
   task automatic t_wrap();
      logic [31:0] d;
      logic [1:0] r;
      int t0;
      wok(`TEC_OFS_CTRL, 32'h0000_0002);
      wok(`TEC_OFS_CTRL, 32'h0000_0000);
      wok(`TEC_OFS_PRE, 32'h0000_0000);
      wok(`TEC_OFS_MATCH0, 32'h0000_0001);
      wok(`TEC_OFS_MATCH0 + 12'h004, 32'h0000_0003);
      wok(`TEC_OFS_MATCH0 + 12'h008, 32'h0000_0002);
      wok(`TEC_OFS_MCTRL, 32'h0000_0010);
      wok(`TEC_OFS_OCTRL, 32'h0000_000D);
      t0 = i_pins.toggles;
      wok(`TEC_OFS_CTRL, 32'h0000_0001);
      repeat (4)
      begin
         repeat (5) @(posedge core_clk);
         axi_rd(`TEC_OFS_COUNT, d, r);
         chk({31'd0, d <= 32'd3}, 32'd1);
      end
      wok(`TEC_OFS_CTRL, 32'h0000_0000);
      chk({31'd0, i_pins.toggles - t0 >= 2}, 32'd1);
      chk({30'd0, match_pin[2], match_pin[0]}, 32'd0);
   endtask : t_wrap
   // events on channel 1 counted; channels 2 and 3 still capture, 3 with and-combine
   task automatic t_events();
      logic [31:0] d;
      logic [1:0] r;
      wok(`TEC_OFS_CTRL, 32'h0000_0002);
      wok(`TEC_OFS_MCTRL, 32'h0000_0000);
      wok(`TEC_OFS_CCTRL, 32'h0000_0A40);
      wok(`TEC_OFS_PINSEL, 32'h0000_00D5);
      wok(`TEC_OFS_ISTAT, 32'h0000_00FF);
      wok(`TEC_OFS_IMASK, 32'h0000_0040);
      wok(`TEC_OFS_CTRL, 32'h0000_0015);
      i_pins.pulse(8'h02, 5);
      rchk(`TEC_OFS_COUNT, 32'h0000_0005);
      i_pins.pulse(8'h04, 1);
      rchk(`TEC_OFS_CAP0 + 12'h008, 32'h0000_0005);
      chk({31'd0, irq_o}, 32'd1);
      i_pins.pulse(8'h08, 1);
      axi_rd(`TEC_OFS_ISTAT, d, r);
      chk({31'd0, d[7]}, 32'd0);
      i_pins.pulse(8'h88, 1);
      axi_rd(`TEC_OFS_ISTAT, d, r);
      chk({31'd0, d[7]}, 32'd1);
      rchk(`TEC_OFS_CAP0 + 12'h00C, 32'h0000_0005);
      wok(`TEC_OFS_CTRL, 32'h0000_0095);
      i_pins.pulse(8'h02, 2);
      rchk(`TEC_OFS_COUNT, 32'h0000_0009);
      wok(`TEC_OFS_CTRL, 32'h0000_0055);
      i_pins.pulse(8'h02, 1);
      rchk(`TEC_OFS_COUNT, 32'h0000_000A);
   endtask : t_events
   // ****************************************
   // sequence, hang guard and verdict
   // ****************************************
   task automatic tally_and_finish();
      bad_count += i_pins.err_cnt;
      $display("checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   // the whole run needs under two thousand clocks
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         $display("Error at %0t: run timed out", $time);
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (6) @(posedge core_clk);
      arst_n <= 1'b1;
      @(posedge core_clk);
      t_regs();
      t_stop();
      t_wrap();
      t_events();
      tally_and_finish();
   end
endmodule : timer_event_counter_bench
`default_nettype wire
